// ==== hrx_regs.svh ====
/*
 * Register offsets, field positions and counts of the receive channel
 * provisioning bank. Assumes byte addresses on a 10-bit register port.
 */
`ifndef HRX_REGS_SVH
`define HRX_REGS_SVH

// ****************************************
// Offsets
// ****************************************
`define HRX_ADDR_CHAN_SEL  10'h200
`define HRX_ADDR_DATA_ONE  10'h204
`define HRX_ADDR_DATA_TWO  10'h208
`define HRX_ADDR_BLK_SEL   10'h210
`define HRX_ADDR_BLK_DATA  10'h214

// ****************************************
// Field positions
// ****************************************
`define HRX_BIT_BUSY       15
`define HRX_BIT_DIR        14
`define HRX_BIT_PROVISIONED 15
`define HRX_BIT_FCS_DISCARD      14
`define HRX_BIT_DELINEATE  13
`define HRX_BIT_XFER_READY 12
`define HRX_BIT_LSB7       15
`define HRX_BIT_PRIO       14
`define HRX_BIT_INVERT     13
`define HRX_LSB_CRC        10
`define HRX_LSB_PAD        8
`define HRX_LSB_XFER       0

// ****************************************
// Values and counts
// ****************************************
`define HRX_CRC_NONE       2'h0
`define HRX_CRC_CCITT      2'h1
`define HRX_CRC_32         2'h2
`define HRX_FCS_CCITT_LEN  3'h2
`define HRX_FCS_32_LEN     3'h4
`define HRX_ACC_CYCLES     4
`define HRX_LAST_BIT       3'h7

`endif

// ==== hrx_pkg.sv ====
/*
 * Types of the receive channel provisioning bank.
 * Assumes hrx_regs.svh for the numeric layout.
 */
package hrx_pkg;

  typedef enum logic {HRX_IDLE, HRX_WAIT} hrx_acc_state_t;

  typedef struct packed {
    logic        provisioned;
    logic        fcs_discard;
    logic        delineate;
    logic [10:0] head_block;
    logic        lsb7;
    logic        prio;
    logic        invert;
    logic [1:0]  crc;
    logic [1:0]  pad;
    logic [3:0]  xfer;
  } hrx_channel_provisioned_t;

endpackage

// ==== hrx_channel_provisioned.sv ====
/*
 * Receive HDLC channel provisioning: staged indirect data registers,
 * channel provision RAM, block pointer RAM and the per-bit front end
 * that applies the provisioned fields to the incoming channel stream.
 * Assumes the stream, FIFO status and register port are all on ref_clk_i.
 */
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "hrx_regs.svh"

// Operation
// - With delineate_enable set, channel bits go to flag search and de-stuffing.
// - With delineate_enable clear, no delineation, de-stuffing or CRC check.
// - fcs_discard with CRC selected keeps check bytes out of the FIFO.
// - With fcs_discard clear, check bytes are written with the frame.
// - fcs_discard and CRC select are ignored when delineate_enable is clear.
// - Descriptor byte count accounts for check bytes actually buffered.
// - Staged fields except head_block read back written values until an indirect read completes.
// - Only channels with channel_provisioned set have their data processed.
// - Request a transfer at transfer_size depth or with an end-of-packet queued.
// - Threshold and burst both equal transfer_size plus one 16-byte blocks.
// - Insert lead_pad_count invalid bytes ahead of each stored packet.
// - CRC select: 00 none, 01 CRC-CCITT, 10 CRC-32, 11 reserved.
// - stream_polarity_flip inverts the channel stream before HDLC handling.
// - Priority channels are serviced before non-priority channels.
// - ignore_octet_lsb drops the last received bit of every octet.
// - Any block-select write starts a block pointer RAM access.
// - Block select: busy bit 15, direction bit 14, block in bits 10..0.
// - Busy rises on a trigger write and falls when the access ends.
// - provision_access_dir 0 writes the channel RAM, 1 reads it back.
// - block_access_dir 0 writes the block RAM, 1 reads it back.
module hrx_channel_provisioned #(
  parameter int ACC_CYCLES = `HRX_ACC_CYCLES,
  parameter int DEPTH_W    = 11
) (
  input  wire logic               ref_clk_i,        // System clock
  input  wire logic               rst_i,            // Synchronous reset, high
  input  wire logic [9:0]         addr_i,           // Register byte address
  input  wire logic [31:0]        wdata_i,          // Register write data
  input  wire logic               wr_i,             // Write strobe
  input  wire logic               rd_i,             // Read strobe
  output logic      [31:0]        rdata_o,          // Read data, cycle after rd_i
  input  wire logic               rx_valid_i,       // Channel bit present
  input  wire logic [7:0]         rx_chan_i,        // Channel of the bit
  input  wire logic               rx_bit_i,         // Bit from channel assigner
  input  wire logic [DEPTH_W-1:0] fifo_blocks_i,    // FIFO depth of rx_chan_i
  input  wire logic               eop_present_i,    // FIFO of rx_chan_i holds EOP
  output logic                    out_valid_o,      // Bit handed to HDLC stage
  output logic      [7:0]         out_chan_o,       // Channel of out_bit_o
  output logic                    out_bit_o,        // Processed bit
  output logic                    delineate_o,      // Flag search and de-stuff on
  output logic      [1:0]         crc_sel_o,        // CRC to verify, 0 when raw
  output logic                    fcs_discard_o,    // Drop check bytes
  output logic      [2:0]         fcs_bytes_o,      // Check bytes kept in buffer
  output logic      [1:0]         lead_pad_o,       // Invalid bytes before packet
  output logic                    priority_o,       // Serve this FIFO first
  output logic                    xfer_req_o,       // Request DMA write
  output logic      [4:0]         burst_blocks_o,   // Blocks per transfer
  input  wire logic [10:0]        bp_addr_i,        // Block pointer lookup
  output logic      [10:0]        bp_data_o         // Next block, cycle later
);

  // ****************************************
  // Storage
  // ****************************************
  hrx_pkg::hrx_channel_provisioned_t channel_provisioned_mem [256];
  logic [10:0]        blk_mem  [2048];
  logic [2:0]         bitpos   [256];
  logic               tav_mem  [256];

  hrx_pkg::hrx_channel_provisioned_t stage;
  hrx_pkg::hrx_channel_provisioned_t cfg_now;
  hrx_pkg::hrx_acc_state_t chan_st;
  hrx_pkg::hrx_acc_state_t blk_st;
  logic               stage_tav;
  logic               chan_dir;
  logic [7:0]         lane_select;
  logic               blk_dir;
  logic [10:0]        list_node_select;
  logic [10:0]        blk_data;
  logic [7:0]         chan_cnt;
  logic [7:0]         blk_cnt;
  logic               chan_done;
  logic               blk_done;
  logic               req_now;
  logic               drop_now;

  assign cfg_now   = channel_provisioned_mem[rx_chan_i];
  assign chan_done = (chan_st == hrx_pkg::HRX_WAIT) && (chan_cnt == 8'h00);
  assign blk_done  = (blk_st == hrx_pkg::HRX_WAIT) && (blk_cnt == 8'h00);

  function automatic logic [4:0] blocks_of(input logic [3:0] xfer);
    return {1'b0, xfer} + 5'h01;
  endfunction

  // ****************************************
  // Channel indirect access
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      chan_st     <= hrx_pkg::HRX_IDLE;
      chan_cnt    <= 8'h00;
      chan_dir    <= 1'b0;
      lane_select <= 8'h00;
    end else if (wr_i && addr_i == `HRX_ADDR_CHAN_SEL) begin
      chan_st     <= hrx_pkg::HRX_WAIT;
      chan_cnt    <= 8'(ACC_CYCLES - 1);
      chan_dir    <= wdata_i[`HRX_BIT_DIR];
      lane_select <= wdata_i[7:0];
    end else begin
      case (chan_st)
        hrx_pkg::HRX_WAIT: begin
          if (chan_cnt == 8'h00) begin
            chan_st <= hrx_pkg::HRX_IDLE;
          end else begin
            chan_cnt <= chan_cnt - 8'h01;
          end
        end
        default: chan_st <= hrx_pkg::HRX_IDLE;
      endcase
    end
  end

  // Write completes from the staged copy; software must not touch it meanwhile
  always_ff @(posedge ref_clk_i) begin
    if (chan_done && !chan_dir) begin
      channel_provisioned_mem[lane_select] <= stage;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      stage     <= '0;
      stage_tav <= 1'b0;
    end else if (chan_done && chan_dir) begin
      stage     <= channel_provisioned_mem[lane_select];
      stage_tav <= tav_mem[lane_select];
    end else if (wr_i && addr_i == `HRX_ADDR_DATA_ONE) begin
      stage.provisioned <= wdata_i[`HRX_BIT_PROVISIONED];
      stage.fcs_discard       <= wdata_i[`HRX_BIT_FCS_DISCARD];
      stage.delineate   <= wdata_i[`HRX_BIT_DELINEATE];
      stage.head_block  <= wdata_i[10:0];
    end else if (wr_i && addr_i == `HRX_ADDR_DATA_TWO) begin
      stage.lsb7   <= wdata_i[`HRX_BIT_LSB7];
      stage.prio   <= wdata_i[`HRX_BIT_PRIO];
      stage.invert <= wdata_i[`HRX_BIT_INVERT];
      stage.crc    <= wdata_i[`HRX_LSB_CRC +: 2];
      stage.pad    <= wdata_i[`HRX_LSB_PAD +: 2];
      stage.xfer   <= wdata_i[`HRX_LSB_XFER +: 4];
    end
  end

  // ****************************************
  // Block pointer indirect access
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      blk_st           <= hrx_pkg::HRX_IDLE;
      blk_cnt          <= 8'h00;
      blk_dir          <= 1'b0;
      list_node_select <= 11'h000;
    end else if (wr_i && addr_i == `HRX_ADDR_BLK_SEL) begin
      blk_st           <= hrx_pkg::HRX_WAIT;
      blk_cnt          <= 8'(ACC_CYCLES - 1);
      blk_dir          <= wdata_i[`HRX_BIT_DIR];
      list_node_select <= wdata_i[10:0];
    end else begin
      case (blk_st)
        hrx_pkg::HRX_WAIT: begin
          if (blk_cnt == 8'h00) begin
            blk_st <= hrx_pkg::HRX_IDLE;
          end else begin
            blk_cnt <= blk_cnt - 8'h01;
          end
        end
        default: blk_st <= hrx_pkg::HRX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (blk_done && !blk_dir) begin
      blk_mem[list_node_select] <= blk_data;
    end
    bp_data_o <= blk_mem[bp_addr_i];
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      blk_data <= 11'h000;
    end else if (blk_done && blk_dir) begin
      blk_data <= blk_mem[list_node_select];
    end else if (wr_i && addr_i == `HRX_ADDR_BLK_DATA) begin
      blk_data <= wdata_i[10:0];
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !rd_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      case (addr_i)
        `HRX_ADDR_CHAN_SEL: rdata_o <= {16'h0000, chan_st == hrx_pkg::HRX_WAIT,
                                        chan_dir, 6'h00, lane_select};
        `HRX_ADDR_DATA_ONE: rdata_o <= {16'h0000, stage.provisioned, stage.fcs_discard,
                                        stage.delineate, stage_tav, 12'h000};
        `HRX_ADDR_DATA_TWO: rdata_o <= {16'h0000, stage.lsb7, stage.prio,
                                        stage.invert, 1'b0, stage.crc,
                                        stage.pad, 4'h0, stage.xfer};
        `HRX_ADDR_BLK_SEL:  rdata_o <= {16'h0000, blk_st == hrx_pkg::HRX_WAIT,
                                        blk_dir, 3'h0, list_node_select};
        `HRX_ADDR_BLK_DATA: rdata_o <= {21'h000000, blk_data};
        default:            rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Per-bit front end
  // ****************************************
  // Octet position counts every provisioned bit so dropping stays aligned
  assign drop_now = cfg_now.lsb7 && (bitpos[rx_chan_i] == `HRX_LAST_BIT);
  assign req_now  = cfg_now.provisioned && (eop_present_i ||
                    fifo_blocks_i >= DEPTH_W'(blocks_of(cfg_now.xfer)));

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 256; i++) begin
        bitpos[i]  <= 3'h0;
        tav_mem[i] <= 1'b0;
      end
    end else if (rx_valid_i && cfg_now.provisioned) begin
      bitpos[rx_chan_i]  <= bitpos[rx_chan_i] + 3'h1;
      tav_mem[rx_chan_i] <= req_now;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      out_valid_o    <= 1'b0;
      out_chan_o     <= 8'h00;
      out_bit_o      <= 1'b0;
      delineate_o    <= 1'b0;
      crc_sel_o      <= `HRX_CRC_NONE;
      fcs_discard_o  <= 1'b0;
      fcs_bytes_o    <= 3'h0;
      lead_pad_o     <= 2'h0;
      priority_o     <= 1'b0;
      xfer_req_o     <= 1'b0;
      burst_blocks_o <= 5'h01;
    end else if (rx_valid_i) begin
      out_valid_o    <= cfg_now.provisioned && !drop_now;
      out_chan_o     <= rx_chan_i;
      out_bit_o      <= rx_bit_i ^ cfg_now.invert;
      delineate_o    <= cfg_now.delineate;
      crc_sel_o      <= cfg_now.delineate ? cfg_now.crc : `HRX_CRC_NONE;
      fcs_discard_o  <= cfg_now.delineate && cfg_now.fcs_discard &&
                        cfg_now.crc != `HRX_CRC_NONE;
      // Reserved CRC code verifies nothing and so buffers no check bytes
      if (!cfg_now.delineate || cfg_now.fcs_discard) begin
        fcs_bytes_o <= 3'h0;
      end else if (cfg_now.crc == `HRX_CRC_CCITT) begin
        fcs_bytes_o <= `HRX_FCS_CCITT_LEN;
      end else if (cfg_now.crc == `HRX_CRC_32) begin
        fcs_bytes_o <= `HRX_FCS_32_LEN;
      end else begin
        fcs_bytes_o <= 3'h0;
      end
      lead_pad_o     <= cfg_now.pad;
      priority_o     <= cfg_now.prio;
      xfer_req_o     <= req_now;
      burst_blocks_o <= blocks_of(cfg_now.xfer);
    end else begin
      out_valid_o <= 1'b0;
      xfer_req_o  <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_chan_busy_ends;
    @(posedge ref_clk_i) disable iff (rst_i)
    $rose(chan_st == hrx_pkg::HRX_WAIT) |-> ##[1:64] (chan_st == hrx_pkg::HRX_IDLE);
  endproperty
  a_chan_busy_ends: assert property (p_chan_busy_ends) else $error("chan busy stuck");

  property p_blk_start;
    @(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == `HRX_ADDR_BLK_SEL) |=> (blk_st == hrx_pkg::HRX_WAIT);
  endproperty
  a_blk_start: assert property (p_blk_start) else $error("block access not started");

  property p_unprov;
    @(posedge ref_clk_i) disable iff (rst_i)
    (rx_valid_i && !cfg_now.provisioned) |=> !out_valid_o && !xfer_req_o;
  endproperty
  a_unprov: assert property (p_unprov) else $error("unprovisioned data passed");

  property p_invert;
    @(posedge ref_clk_i) disable iff (rst_i)
    rx_valid_i |=> out_bit_o == ($past(rx_bit_i) ^ $past(cfg_now.invert));
  endproperty
  a_invert: assert property (p_invert) else $error("polarity wrong");

  property p_raw_mode;
    @(posedge ref_clk_i) disable iff (rst_i)
    !delineate_o |-> crc_sel_o == `HRX_CRC_NONE && !fcs_discard_o && fcs_bytes_o == 3'h0;
  endproperty
  a_raw_mode: assert property (p_raw_mode) else $error("raw channel checks CRC");

  property p_discard;
    @(posedge ref_clk_i) disable iff (rst_i)
    fcs_discard_o |-> delineate_o && crc_sel_o != `HRX_CRC_NONE && fcs_bytes_o == 3'h0;
  endproperty
  a_discard: assert property (p_discard) else $error("discard without CRC");

  property p_burst;
    @(posedge ref_clk_i) disable iff (rst_i)
    rx_valid_i |=> burst_blocks_o == {1'b0, $past(cfg_now.xfer)} + 5'h01;
  endproperty
  a_burst: assert property (p_burst) else $error("burst size wrong");

  property p_unused_zero;
    @(posedge ref_clk_i) disable iff (rst_i)
    rdata_o[31:16] == 16'h0000 && ($past(rd_i) || rdata_o == 32'h0000_0000);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits nonzero");

  property p_eop_request;
    @(posedge ref_clk_i) disable iff (rst_i)
    (rx_valid_i && cfg_now.provisioned && eop_present_i) |=> xfer_req_o;
  endproperty
  a_eop_request: assert property (p_eop_request) else $error("no request on packet end");

  property p_octet_drop;
    @(posedge ref_clk_i) disable iff (rst_i)
    (rx_valid_i && cfg_now.lsb7 && bitpos[rx_chan_i] == `HRX_LAST_BIT) |=> !out_valid_o;
  endproperty
  a_octet_drop: assert property (p_octet_drop) else $error("octet last bit passed");

endmodule // hrx_channel_provisioned

// ==== hrx_channel_provisioned_test.sv ====
/*
 * Self-checking testbench of the receive channel provisioning bank.
 * Assumes hrx_regs.svh for offsets and the default access duration.
 */
`timescale 1ns/1ps
`include "hrx_regs.svh"

module hrx_channel_provisioned_test;
  logic        ref_clk_i;
  logic        rst_i;
  logic [9:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        rx_valid_i;
  logic [7:0]  rx_chan_i;
  logic        rx_bit_i;
  logic [10:0] fifo_blocks_i;
  logic        eop_present_i;
  logic        out_valid_o;
  logic [7:0]  out_chan_o;
  logic        out_bit_o;
  logic        delineate_o;
  logic [1:0]  crc_sel_o;
  logic        fcs_discard_o;
  logic [2:0]  fcs_bytes_o;
  logic [1:0]  lead_pad_o;
  logic        priority_o;
  logic        xfer_req_o;
  logic [4:0]  burst_blocks_o;
  logic [10:0] bp_addr_i;
  logic [10:0] bp_data_o;
  int          fail_count;
  int          compares;
  int          cycles;
  logic [31:0] rv;

  hrx_channel_provisioned hrx_channel_provisioned_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_valid_i(rx_valid_i),
    .rx_chan_i(rx_chan_i), .rx_bit_i(rx_bit_i), .fifo_blocks_i(fifo_blocks_i),
    .eop_present_i(eop_present_i), .out_valid_o(out_valid_o), .out_chan_o(out_chan_o),
    .out_bit_o(out_bit_o), .delineate_o(delineate_o), .crc_sel_o(crc_sel_o),
    .fcs_discard_o(fcs_discard_o), .fcs_bytes_o(fcs_bytes_o), .lead_pad_o(lead_pad_o),
    .priority_o(priority_o), .xfer_req_o(xfer_req_o), .burst_blocks_o(burst_blocks_o),
    .bp_addr_i(bp_addr_i), .bp_data_o(bp_data_o)
  );

  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe is taken
  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic wait_idle(input logic [9:0] a);
    logic [31:0] d;
    int          n;
    n = 0;
    d = 32'h0000_8000;
    while (d[15] !== 1'b0 && n < 20) begin
      rd(a, d);
      n = n + 1;
    end
    chk("busy clears", {31'h0, d[15]}, 32'h0);
  endtask

  task automatic channel_provisioned(input logic [7:0] ch, input logic [31:0] d1, input logic [31:0] d2);
    wr(`HRX_ADDR_DATA_ONE, d1);
    wr(`HRX_ADDR_DATA_TWO, d2);
    wr(`HRX_ADDR_CHAN_SEL, {24'h0, ch});
    wait_idle(`HRX_ADDR_CHAN_SEL);
  endtask

  task automatic bit_in(input logic [7:0] ch, input logic b, input logic [10:0] dep,
                        input logic eop);
    @(posedge ref_clk_i);
    rx_valid_i    <= 1'b1;
    rx_chan_i     <= ch;
    rx_bit_i      <= b;
    fifo_blocks_i <= dep;
    eop_present_i <= eop;
    @(posedge ref_clk_i);
    rx_valid_i    <= 1'b0;
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rd(`HRX_ADDR_DATA_TWO, rv);
    chk("data two reset", rv, 32'h0);
    rd(`HRX_ADDR_BLK_SEL, rv);
    chk("block select reset", rv, 32'h0);
    wr(`HRX_ADDR_DATA_TWO, 32'hFFFF_FFFF);
    rd(`HRX_ADDR_DATA_TWO, rv);
    chk("data two unused bits", rv, 32'h0000_EF0F);
    wr(`HRX_ADDR_DATA_ONE, 32'hFFFF_FFFF);
    rd(`HRX_ADDR_DATA_ONE, rv);
    chk("data one readback", rv, 32'h0000_E000);
    wr(10'h20C, 32'hFFFF_FFFF);
    rd(10'h20C, rv);
    chk("unmapped read", rv, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_chan();
    channel_provisioned(8'h03, 32'h0000_E000, 32'h0000_2601);
    bit_in(8'h03, 1'b1, 11'h002, 1'b0);
    chk("inverted bit", {out_valid_o, out_bit_o}, 32'h2);
    chk("bit channel", {24'h0, out_chan_o}, 32'h3);
    chk("delineate", {31'h0, delineate_o}, 32'h1);
    chk("crc select", {30'h0, crc_sel_o}, 32'h1);
    chk("discard", {31'h0, fcs_discard_o}, 32'h1);
    chk("check bytes kept", {29'h0, fcs_bytes_o}, 32'h0);
    chk("lead pad", {30'h0, lead_pad_o}, 32'h2);
    chk("burst", {27'h0, burst_blocks_o}, 32'h2);
    chk("request at depth", {31'h0, xfer_req_o}, 32'h1);
    bit_in(8'h03, 1'b0, 11'h001, 1'b0);
    chk("no request below depth", {31'h0, xfer_req_o}, 32'h0);
    bit_in(8'h03, 1'b0, 11'h000, 1'b1);
    chk("request on packet end", {31'h0, xfer_req_o}, 32'h1);
    wr(`HRX_ADDR_DATA_TWO, 32'h0);
    wr(`HRX_ADDR_CHAN_SEL, 32'h0000_4003);
    wait_idle(`HRX_ADDR_CHAN_SEL);
    rd(`HRX_ADDR_DATA_TWO, rv);
    chk("read back data two", rv, 32'h0000_2601);
    rd(`HRX_ADDR_DATA_ONE, rv);
    chk("read back data one", rv, 32'h0000_F000);
    $display("test channel done");
  endtask

  task automatic t_modes();
    channel_provisioned(8'h04, 32'h0000_C000, 32'h0000_0800);
    bit_in(8'h04, 1'b1, 11'h0, 1'b0);
    chk("raw delineate off", {31'h0, delineate_o}, 32'h0);
    chk("raw no crc", {30'h0, crc_sel_o}, 32'h0);
    chk("raw no discard", {31'h0, fcs_discard_o}, 32'h0);
    chk("raw check bytes", {29'h0, fcs_bytes_o}, 32'h0);
    channel_provisioned(8'h05, 32'h0, 32'h0);
    bit_in(8'h05, 1'b1, 11'h7FF, 1'b1);
    chk("unprovisioned", {out_valid_o, xfer_req_o}, 32'h0);
    for (int c = 0; c < 4; c++) begin
      channel_provisioned(8'h06, 32'h0000_A000, c << 10);
      bit_in(8'h06, 1'b0, 11'h0, 1'b0);
      chk("kept check bytes", {29'h0, fcs_bytes_o}, (c == 1) ? 2 : (c == 2) ? 4 : 0);
      if (c < 3)
        chk("crc select loop", {30'h0, crc_sel_o}, c);
    end
    channel_provisioned(8'h07, 32'h0000_8000, 32'h0000_C000);
    for (int k = 0; k < 8; k++) begin
      bit_in(8'h07, 1'b1, 11'h0, 1'b0);
      chk("octet bit pass", {31'h0, out_valid_o}, (k < 7) ? 1 : 0);
    end
    chk("priority", {31'h0, priority_o}, 32'h1);
    $display("test modes done");
  endtask

  task automatic t_block();
    wr(`HRX_ADDR_BLK_DATA, 32'h0000_0123);
    wr(`HRX_ADDR_BLK_SEL, 32'h0000_0005);
    rd(`HRX_ADDR_BLK_SEL, rv);
    chk("busy after trigger", rv, 32'h0000_8005);
    wait_idle(`HRX_ADDR_BLK_SEL);
    @(posedge ref_clk_i);
    bp_addr_i <= 11'h005;
    @(posedge ref_clk_i);
    #1 chk("block ram write", {21'h0, bp_data_o}, 32'h123);
    wr(`HRX_ADDR_BLK_DATA, 32'h0000_07FF);
    wr(`HRX_ADDR_BLK_SEL, 32'hFFFF_C005);
    wait_idle(`HRX_ADDR_BLK_SEL);
    rd(`HRX_ADDR_BLK_DATA, rv);
    chk("block ram read", rv, 32'h0000_0123);
    rd(`HRX_ADDR_BLK_SEL, rv);
    chk("block select fields", rv, 32'h0000_4005);
    $display("test block done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    fail_count = 0;
    compares = 0;
    cycles = 0;
    rst_i = 1'b1;
    addr_i = 10'h0;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    rx_valid_i = 1'b0;
    rx_chan_i = 8'h0;
    rx_bit_i = 1'b0;
    fifo_blocks_i = 11'h0;
    eop_present_i = 1'b0;
    bp_addr_i = 11'h0;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_chan();
    t_modes();
    t_block();
    tally_and_finish();
  end
endmodule // hrx_channel_provisioned_test
